// >>> core/ssb_map.vh
// Register map, field positions and timing constants for the serial port core.
// Assumes a 32-bit classic Wishbone slave and a 40 MHz system clock.
// Contract
// - Configurable as serial master or slave.
// - Separate transmit and receive FIFOs, 16x8.
// - Frame size programmable from 4 to 16.
// - SPI, frame-pulse and half-duplex command formats.
// - Loopback routes transmit data into receiver.
// - Serial-to-parallel conversion; registers visible to software.
// - Prescaler divides by even value 2..254.
// - Second stage divides by one plus rate.
// - Bit clock is input over prescale times one plus rate.
// - Pins default GPIO except first port instance.
// - Four pins: clock, frame, receive, transmit.
// - Bit rates of 1.5 MHz and above.
// - Frames shift out most significant bit first.
// - Serial clock idles, toggles only during frames.
// - Four maskable events ORed into one interrupt.
`ifndef SSB_MAP_VH
`define SSB_MAP_VH

`define SSB_OFF_CTRL0     8'h00
`define SSB_OFF_CTRL1     8'h04
`define SSB_OFF_DATA      8'h08
`define SSB_OFF_STATUS    8'h0C
`define SSB_OFF_PRESCALE  8'h10
`define SSB_OFF_INT_STS   8'h14
`define SSB_OFF_INT_EN    8'h18
`define SSB_OFF_INT_CLR   8'h1C

`define SSB_CTRL0_RST     16'h0007
`define SSB_PRESCALE_RST  8'h02
`define SSB_PRESCALE_MIN  8'h02
`define SSB_SIZE_MIN      4'h3
`define SSB_SIZE_MAX      4'hF

`define SSB_FMT_SPI       2'b00
`define SSB_FMT_PULSE     2'b01
`define SSB_FMT_CMD       2'b10

`define SSB_C1_LOOP       0
`define SSB_C1_EN         1
`define SSB_C1_SLAVE      2
`define SSB_C1_ALT        3

`define SSB_INT_TX        0
`define SSB_INT_RX        1
`define SSB_INT_TO        2
`define SSB_INT_OVR       3

`define SSB_CMD_BITS      5'd8
`define SSB_CMD_CAP_START 5'd9
`define SSB_SVC_LEVEL     4'h4
`define SSB_RXTO_TICKS    8'd64

`define SSB_FIFO_DEPTH    4'h8
`define SSB_CLK_HZ        40000000
`define SSB_MIN_RATE_HZ   1500000

`endif

// >>> core/ssb_fifo.v
// Sixteen-bit wide, eight-entry first-in first-out store built of flip-flops.
// Assumes the caller never pushes when full nor pops when empty.
`include "ssb_map.vh"

module ssb_fifo (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        push,
  input  wire [15:0] wdata,
  input  wire        pop,
  output wire [15:0] rdata,
  output wire        empty,
  output wire        full,
  output wire [3:0]  count
);
  reg  [15:0] mem_q [0:7];
  reg  [2:0]  wptr_q;
  reg  [2:0]  rptr_q;
  reg  [3:0]  cnt_q;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_entry
      always @(posedge sys_clk) begin
        if (rst)
          mem_q[i] <= 16'h0000;
        else if (push && (wptr_q == i))
          mem_q[i] <= wdata;
      end
    end
  endgenerate

  always @(posedge sys_clk) begin
    if (rst) begin
      wptr_q <= 3'h0;
      rptr_q <= 3'h0;
      cnt_q  <= 4'h0;
    end else begin
      if (push)
        wptr_q <= wptr_q + 3'h1;
      if (pop)
        rptr_q <= rptr_q + 3'h1;
      if (push && !pop)
        cnt_q <= cnt_q + 4'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 4'h1;
    end
  end

  assign rdata = mem_q[rptr_q];
  assign empty = (cnt_q == 4'h0);
  assign full  = (cnt_q == `SSB_FIFO_DEPTH);
  assign count = cnt_q;
endmodule // ssb_fifo

// >>> core/ssb_core.v
// Synchronous serial port core: Wishbone registers, bit-rate divider,
// frame engine for three formats, FIFOs and interrupt logic.
// Assumes pin inputs already synchronous to sys_clk; pad muxing is outside.
`include "ssb_map.vh"

module ssb_core #(
  parameter FIRST_PORT = 1
) (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        serial_bit_clock_i,
  output reg         serial_bit_clock_o,
  output wire        serial_bit_clock_oe,
  input  wire        frame_select_i,
  output reg         frame_select_o,
  output wire        frame_select_oe,
  input  wire        serial_rx_in,
  output reg         serial_tx_out,
  output wire        alt_function_bit,
  output wire        irq
);
  localparam ST_IDLE = 2'b00;
  localparam ST_RUN  = 2'b01;
  localparam ST_GAP  = 2'b10;

  reg  [15:0] ctrl0_q;
  reg  [3:0]  ctrl1_q;
  reg  [7:0]  prescale_q;
  reg  [3:0]  int_sts_q;
  reg  [3:0]  int_en_q;
  reg  [1:0]  st_q;
  reg  [4:0]  pidx_q;
  reg         half_q;
  reg  [15:0] tx_sh_q;
  reg  [15:0] rx_sh_q;
  reg  [6:0]  pre_q;
  reg  [7:0]  rc_q;
  reg  [7:0]  to_cnt_q;
  reg         sclk_prev_q;

  wire        req     = wb_cyc_i & wb_stb_i;
  wire        wr      = req & wb_we_i & wb_ack_o;
  wire        rd_take = req & ~wb_we_i & ~wb_ack_o;
  wire [31:0] wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wdat    = wb_dat_i & wmask;

  wire        enable  = ctrl1_q[`SSB_C1_EN];
  wire        slave   = ctrl1_q[`SSB_C1_SLAVE];
  wire        loop    = ctrl1_q[`SSB_C1_LOOP];
  wire [1:0]  fmt     = ctrl0_q[5:4];
  wire        ssf     = (fmt == `SSB_FMT_PULSE);
  wire        cmd     = (fmt == `SSB_FMT_CMD);
  wire        spi     = ~ssf & ~cmd;
  wire        pol     = spi & ctrl0_q[6];
  wire        late    = (spi & ctrl0_q[7]) | ssf;
  wire [7:0]  rate    = ctrl0_q[15:8];
  wire [3:0]  sz      = (ctrl0_q[3:0] < `SSB_SIZE_MIN) ? `SSB_SIZE_MIN : ctrl0_q[3:0];
  wire [4:0]  nbits   = {1'b0, sz} + 5'd1;
  wire [4:0]  cap_st  = cmd ? `SSB_CMD_CAP_START : {4'h0, ssf};
  wire [4:0]  total   = cap_st + nbits;
  wire [15:0] wmsk    = 16'hFFFF >> (`SSB_SIZE_MAX - sz);

  // FIFOs
  wire [15:0] tx_rdata;
  wire [15:0] rx_rdata;
  wire        tx_empty;
  wire        tx_full;
  wire        rx_empty;
  wire        rx_full;
  wire [3:0]  tx_cnt;
  wire [3:0]  rx_cnt;
  wire        tx_push = wr & (wb_adr_i == `SSB_OFF_DATA) & ~tx_full & (|wb_sel_i[1:0]);
  wire        rx_pop  = rd_take & (wb_adr_i == `SSB_OFF_DATA) & ~rx_empty;
  wire        tx_pop;
  wire        rx_push;
  wire [15:0] rx_word;

  ssb_fifo u_tx_fifo (
    .sys_clk (sys_clk),
    .rst     (rst),
    .push    (tx_push),
    .wdata   (wdat[15:0]),
    .pop     (tx_pop),
    .rdata   (tx_rdata),
    .empty   (tx_empty),
    .full    (tx_full),
    .count   (tx_cnt)
  );

  ssb_fifo u_rx_fifo (
    .sys_clk (sys_clk),
    .rst     (rst),
    .push    (rx_push & ~rx_full),
    .wdata   (rx_word),
    .pop     (rx_pop),
    .rdata   (rx_rdata),
    .empty   (rx_empty),
    .full    (rx_full),
    .count   (rx_cnt)
  );

  // Divider: each tick is one half bit period, prescale/2 * (1 + rate) sys clocks.
  // At 40 MHz the fastest setting gives 20 MHz, well above the 1.5 MHz floor.
  wire [6:0]  pre_end  = prescale_q[7:1] - 7'h01;
  wire        div_tick = (pre_q == pre_end) & (rc_q == rate);
  wire        m_start  = (st_q == ST_IDLE) & enable & ~slave & ~tx_empty;
  wire        sclk_rise = serial_bit_clock_i & ~sclk_prev_q;
  wire        s_start  = (st_q == ST_IDLE) & enable & slave &
                         (ssf ? (frame_select_i & sclk_rise) : ~frame_select_i);
  wire        start    = m_start | s_start;

  always @(posedge sys_clk) begin
    if (rst || !enable || start) begin
      pre_q <= 7'h00;
      rc_q  <= 8'h00;
    end else if (pre_q == pre_end) begin
      pre_q <= 7'h00;
      rc_q  <= (rc_q == rate) ? 8'h00 : rc_q + 8'h01;
    end else begin
      pre_q <= pre_q + 7'h01;
    end
  end

  // Frame engine, shared by master and slave: tick source, start condition, clock drive, abort and gap differ
  wire        tick     = slave ? (serial_bit_clock_i ^ sclk_prev_q) : div_tick;
  wire        running  = (st_q == ST_RUN);
  wire        lead_ev  = running & tick & ~half_q;
  wire        trail_ev = running & tick & half_q;
  wire        rx_bit   = loop ? serial_tx_out : serial_rx_in;
  wire        cap_ev   = (pidx_q >= cap_st) & (late ? trail_ev : lead_ev);
  wire        tx_ok    = (pidx_q >= {4'h0, ssf});
  wire        launch   = tx_ok & (late ? lead_ev : trail_ev);
  wire        last_ev  = trail_ev & (pidx_q == total - 5'd1);
  wire        s_abort  = slave & running & ~ssf & frame_select_i;
  wire [15:0] rx_next  = cap_ev ? {rx_sh_q[14:0], rx_bit} : rx_sh_q;
  wire [15:0] tx_word  = tx_empty ? 16'h0000 : tx_rdata;
  wire [15:0] tx_align = cmd ? {tx_word[7:0], 8'h00} : (tx_word << (`SSB_SIZE_MAX - sz));

  assign tx_pop  = start & ~tx_empty;
  assign rx_push = last_ev;
  assign rx_word = rx_next & wmsk;

  always @(posedge sys_clk) begin
    if (rst) begin
      st_q               <= ST_IDLE;
      pidx_q             <= 5'd0;
      half_q             <= 1'b0;
      tx_sh_q            <= 16'h0000;
      rx_sh_q            <= 16'h0000;
      serial_tx_out      <= 1'b0;
      serial_bit_clock_o <= 1'b0;
      frame_select_o     <= 1'b1;
      sclk_prev_q        <= 1'b0;
    end else begin
      sclk_prev_q <= serial_bit_clock_i;
      rx_sh_q     <= rx_next;
      case (st_q)
        ST_IDLE: begin
          serial_bit_clock_o <= pol;
          frame_select_o     <= ~ssf;
          serial_tx_out      <= 1'b0;
          pidx_q             <= 5'd0;
          half_q             <= s_start & ssf;
          if (start) begin
            st_q    <= ST_RUN;
            rx_sh_q <= 16'h0000;
            if (~late) begin
              serial_tx_out <= tx_align[15];
              tx_sh_q       <= tx_align << 1;
            end else begin
              tx_sh_q <= tx_align;
            end
            if (~ssf)
              frame_select_o <= 1'b0;
          end
        end
        ST_RUN: begin
          if (tick) begin
            half_q <= ~half_q;
            if (!slave)
              serial_bit_clock_o <= ~serial_bit_clock_o;
            if (half_q)
              pidx_q <= pidx_q + 5'd1;
          end
          if (launch) begin
            serial_tx_out <= tx_sh_q[15];
            tx_sh_q       <= tx_sh_q << 1;
          end
          if (ssf && lead_ev)
            frame_select_o <= (pidx_q == 5'd0);
          if (last_ev || s_abort) begin
            st_q           <= ST_GAP;
            frame_select_o <= ~ssf;
          end
        end
        ST_GAP: begin
          serial_bit_clock_o <= pol;
          // One idle half period keeps the frame select high between SPI frames
          if (tick || slave)
            st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
      if (!enable) begin
        st_q               <= ST_IDLE;
        serial_bit_clock_o <= pol;
      end
    end
  end

  // Clock and frame pins are only driven when the pad is given to this port, master mode runs and loopback is off
  assign serial_bit_clock_oe = alt_function_bit & enable & ~slave & ~loop;
  assign frame_select_oe     = alt_function_bit & enable & ~slave & ~loop;
  assign alt_function_bit    = ctrl1_q[`SSB_C1_ALT];

  // Interrupt events
  wire [3:0] ev;
  assign ev[`SSB_INT_TX]  = (tx_cnt <= `SSB_SVC_LEVEL);
  assign ev[`SSB_INT_RX]  = (rx_cnt >= `SSB_SVC_LEVEL);
  assign ev[`SSB_INT_TO]  = (to_cnt_q == `SSB_RXTO_TICKS - 8'd1) & div_tick;
  assign ev[`SSB_INT_OVR] = rx_push & rx_full;

  always @(posedge sys_clk) begin
    if (rst || (st_q != ST_IDLE) || rx_empty)
      to_cnt_q <= 8'h00;
    else if (div_tick && (to_cnt_q != `SSB_RXTO_TICKS))
      to_cnt_q <= to_cnt_q + 8'h01;
  end

  assign irq = |(int_sts_q & int_en_q);

  // Register file
  wire clr_wr = wr & (wb_adr_i == `SSB_OFF_INT_CLR);

  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl0_q    <= `SSB_CTRL0_RST;
      ctrl1_q    <= {(FIRST_PORT != 0), 3'b000};
      prescale_q <= `SSB_PRESCALE_RST;
      int_en_q   <= 4'h0;
      int_sts_q  <= 4'h0;
    end else begin
      // Hardware set wins over a clear in the same cycle
      int_sts_q <= (int_sts_q & ~(clr_wr ? wdat[3:0] : 4'h0)) | ev;
      if (wr) begin
        case (wb_adr_i)
          `SSB_OFF_CTRL0:
            ctrl0_q <= (ctrl0_q & ~wmask[15:0]) | wdat[15:0];
          `SSB_OFF_CTRL1:
            if (wb_sel_i[0])
              ctrl1_q <= wdat[3:0];
          `SSB_OFF_PRESCALE:
            if (wb_sel_i[0])
              prescale_q <= (wdat[7:0] < `SSB_PRESCALE_MIN) ? `SSB_PRESCALE_MIN
                            : {wdat[7:1], 1'b0};
          `SSB_OFF_INT_EN:
            if (wb_sel_i[0])
              int_en_q <= wdat[3:0];
          default: ;
        endcase
      end
    end
  end

  // Bus answer: ack one cycle after the request, read data registered with it
  always @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (rd_take) begin
        case (wb_adr_i)
          `SSB_OFF_CTRL0:    wb_dat_o <= {16'h0000, ctrl0_q};
          `SSB_OFF_CTRL1:    wb_dat_o <= {28'h000_0000, ctrl1_q};
          `SSB_OFF_DATA:     wb_dat_o <= {16'h0000, rx_empty ? 16'h0000 : rx_rdata};
          `SSB_OFF_STATUS:   wb_dat_o <= {27'h000_0000, (st_q != ST_IDLE), rx_full,
                                          ~rx_empty, ~tx_full, tx_empty};
          `SSB_OFF_PRESCALE: wb_dat_o <= {24'h00_0000, prescale_q};
          `SSB_OFF_INT_STS:  wb_dat_o <= {28'h000_0000, int_sts_q};
          `SSB_OFF_INT_EN:   wb_dat_o <= {28'h000_0000, int_en_q};
          default:           wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // ssb_core

// >>> verif/ssb_core_sva.sv
// Checker for the serial port core: bus handshake, reset state, pin enables, interrupt line.
// Assumes it is bound to ssb_core and sees only that module's ports.
`include "ssb_map.vh"
module ssb_core_sva #(
  parameter FIRST_PORT = 1
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        serial_bit_clock_oe,
  input wire logic        frame_select_o,
  input wire logic        frame_select_oe,
  input wire logic        serial_tx_out,
  input wire logic        alt_function_bit,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  ack_next_a: assert property (disable iff (rst) take |=> wb_ack_o)
    else $error("Request not answered in the next cycle");
  ack_pulse_a: assert property (disable iff (rst) wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge longer than one cycle");
  ack_cause_a: assert property (disable iff (rst) wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("Acknowledge without request");
  rdata_hold_a: assert property (disable iff (rst) !(take && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("Read data changed without a read");
  unmapped_zero_a: assert property (disable iff (rst) take && !wb_we_i && wb_adr_i >= 8'h20 |=> wb_dat_o == 0)
    else $error("Unmapped read not zero");
  oe_pair_a: assert property (disable iff (rst) serial_bit_clock_oe == frame_select_oe)
    else $error("Clock and frame pad enables differ");
  pins_reset_a: assert property (rst |=> frame_select_o && !frame_select_oe && !serial_tx_out)
    else $error("Pins not idle after reset");
  alt_reset_a: assert property (rst |=> alt_function_bit == (FIRST_PORT != 0))
    else $error("Pad function bit wrong after reset");
  irq_reset_a: assert property (rst |=> !irq && !wb_ack_o && wb_dat_o == 0)
    else $error("Interrupt or bus outputs active after reset");
  irq_mask_a: assert property (disable iff (rst)
    wb_ack_o && wb_we_i && wb_adr_i == `SSB_OFF_INT_EN && wb_sel_i[0] && wb_dat_i[3:0] == 4'h0 |=> !irq)
    else $error("Interrupt high with all sources masked");
  cover property (disable iff (rst) wb_ack_o && !wb_we_i);
  cover property (disable iff (rst) $rose(irq));
  cover property (disable iff (rst) serial_bit_clock_oe && !frame_select_o);
endmodule // ssb_core_sva
bind ssb_core ssb_core_sva #(.FIRST_PORT(FIRST_PORT)) ssb_core_sva_inst (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .serial_bit_clock_oe, .frame_select_o,
  .frame_select_oe, .serial_tx_out, .alt_function_bit, .irq);

// >>> verif/ssb_peer.sv
// Model peripheral on the serial pins: clock idle low, sample on rise, shift on fall, MSB first.
// Assumes the frame wire idles high; the clock comes from the core or from a bench master.
module ssb_peer (
  input  wire logic        sck,
  input  wire logic        fss,
  input  wire logic        mosi,
  input  wire logic [15:0] reply,
  input  wire logic [4:0]  nbits,
  output logic             miso,
  output logic [15:0]      got,
  output int               frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sh_q;
  initial begin
    miso = 1'b0;
    got = 16'h0000;
    frames = 0;
  end
  always @(negedge fss) begin
    sh_q = reply << (16 - nbits);
    miso = sh_q[15];
    // Each frame starts a fresh capture so got holds only that frame's word
    got = 16'h0000;
  end
  always @(posedge sck) if (!fss) got = {got[14:0], mosi};
  always @(negedge sck) if (!fss) begin
    sh_q = sh_q << 1;
    miso = sh_q[15];
  end
  // Released line must not keep showing the last bit
  always @(posedge fss) begin
    miso = ~miso;
    frames = frames + 1;
  end
endmodule // ssb_peer

// >>> verif/test_sync_serial_bit_rate_core.sv
// Self-checking bench: registers over Wishbone, master frames to a model peripheral, loopback.
// Assumes FIRST_PORT is left at one and a 40 MHz clock.
`include "ssb_map.vh"
module test_sync_serial_bit_rate_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] q;
  logic        sck_q = 1'b0;
  logic        sck_drv = 1'b0;
  logic        fss_drv = 1'b1;
  wire  [31:0] rdat;
  wire  [15:0] got;
  wire         ack, sck_o, sck_oe, fss_o, fss_oe, tx, rx, alt, irq;
  int          frames, error_cnt, checks_done, cyc_n, last_rise, per, rise_cnt, f0, r0;
  // Idle clock pad rests low; frame pad is pulled up
  wire         sck_w = sck_oe ? sck_o : sck_drv;
  wire         fss_w = fss_oe ? fss_o : fss_drv;
  logic [71:0] rows [0:7] = '{
    {`SSB_OFF_PRESCALE, 32'h0000_00FF, 32'h0000_00FE},
    {`SSB_OFF_PRESCALE, 32'h0000_0001, 32'h0000_0002},
    {`SSB_OFF_CTRL0, 32'h0000_FF2F, 32'h0000_FF2F},
    {`SSB_OFF_CTRL0, 32'h0000_0013, 32'h0000_0013},
    {8'h40, 32'h0000_1234, 32'h0000_0000},
    {`SSB_OFF_STATUS, 32'h0000_00FF, 32'h0000_0003},
    {`SSB_OFF_INT_STS, 32'h0000_000F, 32'h0000_0001},
    {`SSB_OFF_CTRL1, 32'h0000_0008, 32'h0000_0008}};
  logic [19:0] lb [0:2] = '{20'h3_0009, 20'hF_BEEF, 20'hB_0ABC};
  always #12.5 sys_clk = ~sys_clk;
  ssb_core ssb_core_inst (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .serial_bit_clock_i(sck_w), .serial_bit_clock_o(sck_o), .serial_bit_clock_oe(sck_oe),
    .frame_select_i(fss_w), .frame_select_o(fss_o), .frame_select_oe(fss_oe), .serial_rx_in(rx),
    .serial_tx_out(tx), .alt_function_bit(alt), .irq(irq));
  ssb_peer ssb_peer_inst (.sck(sck_w), .fss(fss_w), .mosi(tx), .reply(16'h00C5), .nbits(5'd8),
    .miso(rx), .got(got), .frames(frames));
  always @(posedge sys_clk) begin
    cyc_n <= cyc_n + 1;
    sck_q <= sck_w;
    if (sck_w === 1'b1 && sck_q === 1'b0) begin
      rise_cnt <= rise_cnt + 1;
      if (rise_cnt == 1) per <= cyc_n - last_rise;
      last_rise <= cyc_n;
    end
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      give_verdict;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    cmp(q, e);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      xfer(1'b0, `SSB_OFF_STATUS, 32'h0000_0000);
      n++;
    end while ((q[4] !== 1'b0 || q[0] !== 1'b1) && n < 400);
    if (n >= 400) begin
      error_cnt++;
      give_verdict;
    end
  endtask
  // Bench acts as external master: eight bits, half period of six system clocks
  task automatic slave_frame;
    fss_drv <= 1'b0;
    for (int b = 0; b < 8; b++) begin
      repeat (6) @(posedge sys_clk);
      sck_drv <= 1'b1;
      repeat (6) @(posedge sys_clk);
      sck_drv <= 1'b0;
      if (b == 7) fss_drv <= 1'b1;
    end
  endtask
  task automatic do_reset(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge sys_clk);
    rst <= 1'b0;
  endtask
  initial begin
    do_reset(10);
    rd(`SSB_OFF_CTRL0, 32'h0000_0007);
    rd(`SSB_OFF_PRESCALE, 32'h0000_0002);
    rd(`SSB_OFF_CTRL1, 32'h0000_0008);
    cmp({31'h0, alt}, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, rows[i][71:64], rows[i][63:32]);
      rd(rows[i][71:64], rows[i][31:0]);
    end
    // Half period of four system clocks keeps the bit clock well under half rate
    xfer(1'b1, `SSB_OFF_PRESCALE, 32'h0000_0004);
    xfer(1'b1, `SSB_OFF_CTRL0, 32'h0000_0107);
    for (int i = 0; i < 9; i++) xfer(1'b1, `SSB_OFF_DATA, 32'h0000_0080 + i);
    rd(`SSB_OFF_STATUS, 32'h0000_0000);
    f0 = frames;
    xfer(1'b1, `SSB_OFF_CTRL1, 32'h0000_000A);
    wait_idle;
    cmp(frames - f0, 8);
    cmp(per, 8);
    cmp(rise_cnt, 64);
    cmp({16'h0000, got}, 32'h0000_0087);
    rd(`SSB_OFF_STATUS, 32'h0000_000F);
    r0 = rise_cnt;
    repeat (40) @(posedge sys_clk);
    cmp(rise_cnt - r0, 0);
    cmp({31'h0, sck_w}, 32'h0000_0000);
    xfer(1'b1, `SSB_OFF_DATA, 32'h0000_000E);
    wait_idle;
    cmp({16'h0000, got}, 32'h0000_000E);
    xfer(1'b0, `SSB_OFF_INT_STS, 32'h0000_0000);
    cmp(q & 32'h0000_0008, 32'h0000_0008);
    cmp({31'h0, irq}, 32'h0000_0000);
    xfer(1'b1, `SSB_OFF_INT_EN, 32'h0000_0008);
    @(posedge sys_clk);
    cmp({31'h0, irq}, 32'h0000_0001);
    xfer(1'b1, `SSB_OFF_INT_CLR, 32'h0000_0008);
    @(posedge sys_clk);
    cmp({31'h0, irq}, 32'h0000_0000);
    xfer(1'b1, `SSB_OFF_INT_EN, 32'h0000_0000);
    for (int i = 0; i < 8; i++) rd(`SSB_OFF_DATA, 32'h0000_00C5);
    rd(`SSB_OFF_DATA, 32'h0000_0000);
    f0 = frames;
    xfer(1'b1, `SSB_OFF_CTRL1, 32'h0000_000B);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, `SSB_OFF_CTRL0, {16'h0000, 8'h01, 4'h0, lb[i][19:16]});
      xfer(1'b1, `SSB_OFF_DATA, {16'h0000, lb[i][15:0]});
      wait_idle;
      rd(`SSB_OFF_DATA, {16'h0000, lb[i][15:0]});
    end
    cmp(frames - f0, 0);
    xfer(1'b1, `SSB_OFF_CTRL1, 32'h0000_000E);
    xfer(1'b1, `SSB_OFF_CTRL0, 32'h0000_0107);
    xfer(1'b1, `SSB_OFF_DATA, 32'h0000_005A);
    slave_frame;
    wait_idle;
    cmp({16'h0000, got}, 32'h0000_005A);
    rd(`SSB_OFF_DATA, 32'h0000_00C5);
    do_reset(2);
    rd(`SSB_OFF_CTRL0, 32'h0000_0007);
    give_verdict;
  end
endmodule // test_sync_serial_bit_rate_core
